// ==== ssr_pkg.sv ====
// shared constants and types of the shift-and-store register
package ssr_pkg;

  // shift chain geometry
  localparam int STAGES         = 8;
  localparam int PRE_RISE_INDEX = 6;
  localparam int PRE_FALL_INDEX = 7;

  // event buffer geometry
  localparam int FIFO_DEPTH = 32;

  // pin input conditioning: three flip-flops per pin
  localparam int SYNC_DEPTH = 3;

  // pin positions in the conditioned input vector
  localparam int PIN_COUNT = 4;
  localparam int PIN_CLOCK = 0;
  localparam int PIN_DATA  = 1;
  localparam int PIN_GATE  = 2;
  localparam int PIN_OE    = 3;

  // event word layout pushed into the buffer
  localparam int EV_WIDTH = 4;
  localparam int EV_GATE  = 0;
  localparam int EV_DATA  = 1;
  localparam int EV_FALL  = 2;
  localparam int EV_RISE  = 3;

  // reset values
  localparam logic [STAGES-1:0]    STAGE_RESET = 8'h00;
  localparam logic [PIN_COUNT-1:0] PIN_RESET   = 4'h0;
  localparam logic                 BIT_RESET   = 1'h0;

  typedef logic [STAGES-1:0]   ssr_word_type;
  typedef logic [EV_WIDTH-1:0] ssr_event_type;

endpackage : ssr_pkg

// ==== ssr_fifo_if.sv ====
// handshake bundle between the pin front end, the event buffer and the shift engine
`timescale 1ns/10ps
interface ssr_fifo_if #(
  parameter int WIDTH = 4
);
  logic             push_valid;
  logic             push_ready;
  logic [WIDTH-1:0] push_data;
  logic             pop_valid;
  logic             pop_ready;
  logic [WIDTH-1:0] pop_data;

  // filling side, draining side and the buffer itself
  modport source (output push_valid, output push_data, input push_ready);
  modport sink   (input pop_valid, input pop_data, output pop_ready);
  modport buffer (input push_valid, input push_data, output push_ready,
                  output pop_valid, output pop_data, input pop_ready);
endinterface : ssr_fifo_if

// ==== ssr_fifo.sv ====
// parameterised first-in first-out buffer with valid and ready on both sides
`timescale 1ns/10ps
module ssr_fifo #(
  parameter int WIDTH = 4,
  parameter int DEPTH = 32
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic arst_n,
  // both handshake sides
  ssr_fifo_if.buffer port
);
  localparam int AW = $clog2(DEPTH);

  // pointers only wrap correctly on a power of two
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_check
    $error("ssr_fifo: DEPTH must be a power of two of at least 2");
  end
  if (WIDTH < 1) begin : g_check_w
    $error("ssr_fifo: WIDTH must be at least 1");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;

  wire        full      = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  wire        empty     = (wr_ptr == rd_ptr);
  wire        do_push   = port.push_valid && !full;
  wire        do_pop    = port.pop_ready && !empty;
  wire [AW:0] ptr_step  = {{AW{1'b0}}, 1'b1};

  // handshake outputs are plain decodes of the pointers
  assign port.push_ready = !full;
  assign port.pop_valid  = !empty;
  assign port.pop_data   = mem[rd_ptr[AW-1:0]];

  // storage carries no reset; only the pointers define content
  always_ff @(posedge clk) begin
    if (do_push) begin
      mem[wr_ptr[AW-1:0]] <= port.push_data;
    end
  end

  // pointer update
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (do_push) wr_ptr <= wr_ptr + ptr_step;
      if (do_pop)  rd_ptr <= rd_ptr + ptr_step;
    end
  end

endmodule : ssr_fifo

// ==== ssr_shift_store.sv ====
// eight-stage shift-and-store register with gated storage latches and two serial outputs
//
// Overview of operation
// - an eight-stage shift chain fed from one serial input, each stage with its own storage latch driving one parallel output.
// - on each rising shift clock edge stage zero takes the serial input and each later stage takes its predecessor.
// - while the transfer gate is high the latches follow the stages, and while it is low they hold.
// - while the output enable is high the latch contents are driven on the parallel outputs.
// - while the output enable is low the parallel outputs float, and the serial outputs keep working.
// - on each rising edge the seventh stage moves into the eighth, which is the rising serial output.
// - after a rising edge the rising serial output equals what stage six held just before that edge.
// - the falling serial output repeats the same bit half a clock later and holds it to the next falling edge.
// - on a falling edge only the falling serial output changes, loading what stage seven held before it.
`timescale 1ns/10ps
module ssr_shift_store
  import ssr_pkg::*;
#(
  parameter int WIDTH = STAGES,
  parameter int DEPTH = FIFO_DEPTH
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             arst_n,
  // pins from the host, asynchronous to clk
  input  wire logic             shift_clock,
  input  wire logic             serial_in,
  input  wire logic             transfer_gate,
  input  wire logic             output_enable,
  // parallel outputs, tri-state as data plus enable
  output logic      [WIDTH-1:0] parallel_out,
  output logic                  parallel_out_oe,
  // cascade outputs
  output logic                  serial_out_rise,
  output logic                  serial_out_fall,
  // event buffer control
  input  wire logic             apply_hold,
  output logic                  buffer_ready
);

  // the stage indices of the cascade taps are fixed for the eight-stage part
  if (WIDTH != STAGES || DEPTH < 2) begin : g_check
    $error("ssr_shift_store: WIDTH must equal STAGES and DEPTH be at least 2");
  end

  // ---------------------------------------------------------------
  // pin conditioning
  // ---------------------------------------------------------------
  wire  [PIN_COUNT-1:0] pin_raw = {output_enable, transfer_gate, serial_in, shift_clock};
  logic [PIN_COUNT-1:0] pin_filt;
  logic [PIN_COUNT-1:0] pin_prev;

  // three flops per pin; a change counts once the second and third agree
  for (genvar p = 0; p < PIN_COUNT; p++) begin : g_sync
    logic [SYNC_DEPTH-1:0] sreg;
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        sreg        <= '0;
        pin_filt[p] <= BIT_RESET;
      end else begin
        sreg <= {sreg[SYNC_DEPTH-2:0], pin_raw[p]};
        if (sreg[1] == sreg[2]) pin_filt[p] <= sreg[2];
      end
    end
  end

  // previous filtered level for edge detection
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_prev <= PIN_RESET;
    end else begin
      pin_prev <= pin_filt;
    end
  end

  // ---------------------------------------------------------------
  // event capture: clock edges and gate changes keep their order
  // ---------------------------------------------------------------
  wire clk_rise    = pin_filt[PIN_CLOCK] && !pin_prev[PIN_CLOCK];
  wire clk_fall    = !pin_filt[PIN_CLOCK] && pin_prev[PIN_CLOCK];
  wire gate_change = pin_filt[PIN_GATE] != pin_prev[PIN_GATE];

  ssr_fifo_if #(.WIDTH(EV_WIDTH)) ev_if ();

  // gate changes ride in the buffer too, so a pulse lands between the right shifts
  assign ev_if.push_valid              = clk_rise || clk_fall || gate_change;
  assign ev_if.push_data[EV_RISE]      = clk_rise;
  assign ev_if.push_data[EV_FALL]      = clk_fall;
  assign ev_if.push_data[EV_DATA]      = pin_filt[PIN_DATA];
  assign ev_if.push_data[EV_GATE]      = pin_filt[PIN_GATE];
  assign buffer_ready                  = ev_if.push_ready;

  ssr_fifo #(
    .WIDTH (EV_WIDTH),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk    (clk),
    .arst_n (arst_n),
    .port   (ev_if.buffer)
  );

  // ---------------------------------------------------------------
  // shift engine
  // ---------------------------------------------------------------
  ssr_word_type stage;
  ssr_word_type latch;
  logic         gate_level;

  // the engine stalls while hold is high, which is what lets the buffer fill
  assign ev_if.pop_ready = !apply_hold;

  wire           ev_take  = ev_if.pop_valid && !apply_hold;
  ssr_event_type ev;
  assign ev = ev_if.pop_data;

  wire ev_rise = ev_take && ev[EV_RISE];
  wire ev_fall = ev_take && ev[EV_FALL];

  wire pre_rise_stage_bit = stage[PRE_RISE_INDEX];
  wire pre_fall_stage_bit = stage[PRE_FALL_INDEX];

  // stage zero takes the serial bit, the rest move up one place;
  // stage six feeds the top stage, which is the rising cascade output
  wire ssr_word_type shifted    = {pre_rise_stage_bit, stage[WIDTH-3:0], ev[EV_DATA]};
  wire ssr_word_type next_stage = ev_rise ? shifted : stage;
  wire               next_gate  = ev_take ? ev[EV_GATE] : gate_level;

  // latches are transparent while the gate is high, seeing the freshly shifted word
  wire ssr_word_type next_latch = next_gate ? next_stage : latch;

  // chain and latches
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stage      <= STAGE_RESET;
      latch      <= STAGE_RESET;
      gate_level <= BIT_RESET;
    end else begin
      stage      <= next_stage;
      latch      <= next_latch;
      gate_level <= next_gate;
    end
  end

  // the last stage is itself the rising cascade output
  assign serial_out_rise = stage[PRE_FALL_INDEX];

  // falling output copies stage seven on a falling edge only
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      serial_out_fall <= BIT_RESET;
    end else if (ev_fall) begin
      serial_out_fall <= pre_fall_stage_bit;
    end
  end

  // parallel drive; enable is not buffered so it acts without waiting on shifts
  assign parallel_out    = latch;
  assign parallel_out_oe = pin_filt[PIN_OE];

endmodule : ssr_shift_store

// ==== ssr_chk.sv ====
// port-level checks of the shift-and-store register
`timescale 1ns/10ps
module ssr_chk
  import ssr_pkg::*;
#(
  parameter int WIDTH = STAGES,
  parameter int DEPTH = FIFO_DEPTH
) (
  // clock, reset and host pins
  input wire logic             clk,
  input wire logic             arst_n,
  input wire logic             shift_clock,
  input wire logic             serial_in,
  input wire logic             transfer_gate,
  input wire logic             output_enable,
  // outputs and buffer control
  input wire logic [WIDTH-1:0] parallel_out,
  input wire logic             parallel_out_oe,
  input wire logic             serial_out_rise,
  input wire logic             serial_out_fall,
  input wire logic             apply_hold,
  input wire logic             buffer_ready
);
  logic [5:0] run_cnt;
  logic       settled;
  // a stall leaves a backlog, so pin-level checks wait until it has surely drained
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n) run_cnt <= 6'h00;
    else if (apply_hold) run_cnt <= 6'h00;
    else if (run_cnt != 6'h3F) run_cnt <= run_cnt + 6'h01;
  assign settled = (run_cnt == 6'h3F);

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  chk_oe_off: assert property (!output_enable [*6] |-> !parallel_out_oe)
    else $error("outputs not floating");
  chk_oe_on: assert property (output_enable [*6] |-> parallel_out_oe)
    else $error("outputs not driven");
  chk_hold_word: assert property ((!transfer_gate && settled) [*8] |=> $stable(parallel_out))
    else $error("latches moved with gate low");
  // a rise reaches the engine six edges after the pin; the fall output must not move then
  chk_fall_stable: assert property (($rose(shift_clock) && settled) |->
      ##6 $stable(serial_out_fall))
    else $error("fall output moved on a rising edge");
  chk_rise_stable: assert property ((!shift_clock && settled) [*8] |=> $stable(serial_out_rise))
    else $error("rise output moved while clock low");
  chk_fall_copy: assert property ($changed(serial_out_fall) |-> serial_out_fall == serial_out_rise)
    else $error("fall output not a copy of last stage");
  chk_latch_follow: assert property ((transfer_gate && settled) [*8] |-> parallel_out[7] == serial_out_rise)
    else $error("latch not following stage");
  chk_rise_stage: assert property (transfer_gate [*8] ##0 (settled && $changed(serial_out_rise)) |-> serial_out_rise == $past(parallel_out[6]))
    else $error("rise output not previous stage six");
endmodule : ssr_chk

bind ssr_shift_store ssr_chk #(.WIDTH(WIDTH), .DEPTH(DEPTH)) i_chk (
  .clk(clk), .arst_n(arst_n), .shift_clock(shift_clock), .serial_in(serial_in),
  .transfer_gate(transfer_gate), .output_enable(output_enable),
  .parallel_out(parallel_out), .parallel_out_oe(parallel_out_oe),
  .serial_out_rise(serial_out_rise), .serial_out_fall(serial_out_fall),
  .apply_hold(apply_hold), .buffer_ready(buffer_ready));

// ==== ssr_host.sv ====
// host controller model driving the shift, data, gate and enable pins
`timescale 1ns/10ps
module ssr_host (
  // clock and enable request
  input  wire logic clk,
  input  wire logic oe_req,
  // pins towards the block
  output logic      shift_clock,
  output logic      serial_in,
  output logic      transfer_gate,
  output logic      output_enable
);
  initial begin
    shift_clock = 1'h0;
    serial_in = 1'h0;
    transfer_gate = 1'h0;
    output_enable = 1'h1;
  end
  always @(negedge clk) output_enable <= oe_req;
  task automatic wait_n(input int n);
    repeat (n) @(negedge clk);
  endtask : wait_n
  // phases of 5 clk each, above the 4 the pin filter needs; g: 1 pulse, 2 held
  task automatic load(input logic [7:0] w, input int n, input int g);
    if (g == 2) transfer_gate = 1'h1;
    for (int i = n - 1; i >= 0; i--) begin
      serial_in = w[i];
      wait_n(5);
      shift_clock = 1'h1;
      wait_n(5);
      shift_clock = 1'h0;
      wait_n(5);
    end
    serial_in = ~serial_in; // hold time over, show a wrong bit
    if (g == 1) begin
      transfer_gate = 1'h1;
      wait_n(6);
    end
    transfer_gate = 1'h0;
  endtask : load
endmodule : ssr_host

// ==== tb.sv ====
// self-checking bench for the shift-and-store register
`timescale 1ns/10ps
module tb;
  import ssr_pkg::*;
  logic clk, arst_n, oe_req, apply_hold, sample;
  logic shift_clock, serial_in, transfer_gate, output_enable;
  logic parallel_out_oe, serial_out_rise, serial_out_fall, buffer_ready;
  ssr_word_type parallel_out, w, prev;
  logic [10:0] notes[$];
  logic [31:0] seed = 32'hD547;
  int failures = 0, checked = 0, cycles = 0;
  initial clk = 1'h0;
  always #5 clk = ~clk;
  ssr_host i_host (.clk(clk), .oe_req(oe_req), .shift_clock(shift_clock),
    .serial_in(serial_in), .transfer_gate(transfer_gate), .output_enable(output_enable));
  ssr_shift_store i_dut (.clk(clk), .arst_n(arst_n), .shift_clock(shift_clock),
    .serial_in(serial_in), .transfer_gate(transfer_gate), .output_enable(output_enable),
    .parallel_out(parallel_out), .parallel_out_oe(parallel_out_oe),
    .serial_out_rise(serial_out_rise), .serial_out_fall(serial_out_fall),
    .apply_hold(apply_hold), .buffer_ready(buffer_ready));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic check(input logic [10:0] seen, input logic [10:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic complete_run();
    $display("failures=%0d checked=%0d", failures, checked);
    if (failures == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : complete_run
  // note the expected outputs once the pipeline has settled, then flag a sample
  task automatic expect_out(input logic oe, input ssr_word_type p);
    i_host.wait_n(14);
    notes.push_back({oe, p[7], p[7], p});
    sample = 1'h1;
    i_host.wait_n(1);
    sample = 1'h0;
  endtask : expect_out
  // watcher takes the oldest note whenever a sample is flagged
  always @(posedge clk) begin
    cycles++;
    if (sample && notes.size() > 0)
      check({parallel_out_oe, serial_out_rise, serial_out_fall, parallel_out}, notes.pop_front());
    if (cycles == 20000) begin
      failures++;
      complete_run();
    end
  end
  initial begin
    arst_n = 1'h0;
    oe_req = 1'h1;
    apply_hold = 1'h0;
    sample = 1'h0;
    repeat (10) @(negedge clk);
    arst_n = 1'h1;
    i_host.wait_n(2);
    // random words loaded then strobed, one with the outputs floating
    for (int k = 0; k < 5; k++) begin
      seed = lfsr(seed);
      w = seed[7:0];
      oe_req = (k != 3);
      i_host.load(w, 8, 1);
      expect_out(k != 3, w);
      prev = w;
    end
    // shifting with the gate low leaves the latches alone
    w = ~prev;
    i_host.load(w, 8, 0);
    notes.push_back({1'h1, w[7], w[7], prev});
    i_host.wait_n(14);
    sample = 1'h1;
    i_host.wait_n(1);
    sample = 1'h0;
    // gate held high makes the latches transparent
    seed = lfsr(seed);
    w = seed[15:8];
    i_host.load(w, 8, 2);
    expect_out(1'h1, w);
    // stalled engine: 32 events fill the buffer, the third word is lost
    apply_hold = 1'h1;
    w = seed[23:16];
    i_host.load(8'h3C, 8, 0);
    i_host.load(w, 8, 0);
    i_host.load(~w, 8, 0);
    check({10'h000, buffer_ready}, 11'h000);
    apply_hold = 1'h0;
    i_host.wait_n(40);
    check({10'h000, buffer_ready}, 11'h001);
    i_host.load(8'h00, 0, 1);
    expect_out(1'h1, w);
    complete_run();
  end
endmodule : tb
